// ==== design/rhp_port_config.sv ====
// How it works
// - Command 13 hex returns the 32-bit register on the next cycle and 93 hex writes it.
// - In per-port mode a masked port changes power only on its own per-port command.
// - In per-port mode an unmasked port changes power only on the global commands.
// - In global mode the mask is ignored and every port follows the global commands.
// - Mask bit 2 is port 2, bit 1 is port 1, bit 0 has no port.
// - A fixed-device bit reads one for a permanent device and zero for a removable one.
// - Fixed-device bit 2 is port 2, bit 1 is port 1, bit 0 has no port.
// - Bits 31 to 19 and 15 to 3 are reserved; only 18, 17, 2 and 1 are writable, bits 16 and 0 drop writes.
// - Select bit zero powers all ports together, one powers masked ports individually.
// - In per-port mode a global power-on sets only unmasked ports.
// - In per-port mode a global power-off clears only unmasked ports.
`timescale 1ns/100ps
module rhp_port_config
  import rhp_pkg::*;
(
  input  wire logic           clk,
  input  wire logic           reset_n,
  input  wire logic           cmd_valid,
  input  wire logic [7:0]     cmd_code,
  input  wire logic [31:0]    cmd_wdata,
  input  wire logic           switch_select_bit,
  input  wire rhp_power_cmd_t power_cmd,
  output logic [31:0]         cmd_rdata,
  output logic                cmd_rvalid,
  output logic [2:0]          port_powered_flag,
  output logic [2:0]          fixed_device_flags
);

  logic [2:0]  port_power_mask;
  logic [2:0]  next_powered;
  logic [31:0] reg_image;
  logic [2:0]  wr_mask;
  logic [2:0]  wr_fixed;
  logic        do_write;
  logic        do_read;
  logic        other_code;

  // True when a strobed command carries the given code; shared by the read and write decode.
  function automatic logic cmd_hit(input logic valid, input logic [7:0] code,
                                   input logic [7:0] want);
    return valid && (code == want);
  endfunction : cmd_hit

  // True when a port is steered by its own per-port commands; global mode ignores the mask.
  function automatic logic port_masked(input logic sel, input logic mask_bit);
    return sel && mask_bit;
  endfunction : port_masked

  // Command decode; any other code leaves this register untouched.
  assign do_write   = cmd_hit(cmd_valid, cmd_code, RHP_CMD_WRITE);
  assign do_read    = cmd_hit(cmd_valid, cmd_code, RHP_CMD_READ);
  assign other_code = cmd_valid && !do_write && !do_read;

  // Write fields cut from the data word; only port bits survive, so bit 0 drops writes.
  assign wr_mask  = cmd_wdata[RHP_MASK_LSB +: RHP_FIELD_W] & RHP_PORT_BITS;
  assign wr_fixed = cmd_wdata[RHP_FIXED_LSB +: RHP_FIELD_W] & RHP_PORT_BITS;

  // Read image: reserved positions are forced to zero.
  assign reg_image = {13'h0000, port_power_mask, 13'h0000, fixed_device_flags};

  // Field storage; only port bits are kept so bit 0 and reserved bits drop writes.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      port_power_mask    <= RHP_MASK_RESET;
      fixed_device_flags <= RHP_FIXED_RESET;
    end else if (do_write) begin
      port_power_mask    <= wr_mask;
      fixed_device_flags <= wr_fixed;
    end
  end

  // Read answer one cycle after the command, held until the next read.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cmd_rdata  <= RHP_RDATA_RESET;
      cmd_rvalid <= 1'b0;
    end else begin
      cmd_rvalid <= do_read;
      if (do_read) begin
        cmd_rdata <= reg_image;
      end
    end
  end

  // Per-port power steering; off wins over on when both arrive for one port.
  genvar g;
  generate
    for (g = 1; g <= RHP_NUM_PORTS; g++) begin : g_port
      logic masked;
      logic turn_on;
      logic turn_off;
      // Global mode ignores the mask entirely.
      assign masked   = port_masked(switch_select_bit, port_power_mask[g]);
      assign turn_on  = masked ? power_cmd.port_on[g] : power_cmd.all_on;
      assign turn_off = masked ? power_cmd.port_off[g] : power_cmd.all_off;
      assign next_powered[g] = turn_off ? 1'b0 : (turn_on ? 1'b1 : port_powered_flag[g]);
    end
  endgenerate
  assign next_powered[0] = 1'b0;

  // Powered flags; after reset every port stays unpowered until a command asks for power.
  // The flags are registered so the power switches never see a decode glitch.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      port_powered_flag <= RHP_POWER_RESET;
    end else begin
      port_powered_flag <= next_powered;
    end
  end

  // Checks next to the logic.
  a_read_answer: assert property (@(posedge clk) disable iff (!reset_n)
    do_read |=> (cmd_rvalid && cmd_rdata == $past(reg_image)))
    else $error("read answer wrong");
  a_write_takes: assert property (@(posedge clk) disable iff (!reset_n)
    do_write |=> (port_power_mask == ($past(cmd_wdata[18:16]) & 3'h6)))
    else $error("write not stored");
  a_reserved_zero: assert property (@(posedge clk) disable iff (!reset_n)
    cmd_rvalid |-> (cmd_rdata[31:19] == 13'h0000 && cmd_rdata[15:3] == 13'h0000
                    && cmd_rdata[16] == 1'b0 && cmd_rdata[0] == 1'b0))
    else $error("reserved bit set");
  a_masked_hold: assert property (@(posedge clk) disable iff (!reset_n)
    (switch_select_bit && port_power_mask[1] && !power_cmd.port_on[1] && !power_cmd.port_off[1])
    |=> $stable(port_powered_flag[1]))
    else $error("masked port moved on global");
  a_global_on: assert property (@(posedge clk) disable iff (!reset_n)
    (!switch_select_bit && power_cmd.all_on && !power_cmd.all_off) |=> port_powered_flag[2:1] == 2'h3)
    else $error("global on missed");
  a_unmasked_off: assert property (@(posedge clk) disable iff (!reset_n)
    (switch_select_bit && !port_power_mask[2] && power_cmd.all_off) |=> !port_powered_flag[2])
    else $error("global off missed");
  a_unmasked_on: assert property (@(posedge clk) disable iff (!reset_n)
    (switch_select_bit && !port_power_mask[1] && power_cmd.all_on && !power_cmd.all_off)
    |=> port_powered_flag[1])
    else $error("global on missed unmasked");
  a_port_bit0: assert property (@(posedge clk) disable iff (!reset_n)
    !port_powered_flag[0] && !fixed_device_flags[0])
    else $error("bit 0 set");

  // The answer strobe only follows a read, and the held data only moves on a read.
  a_read_quiet: assert property (@(posedge clk) disable iff (!reset_n)
    !do_read |=> !cmd_rvalid)
    else $error("read answer without a read");
  a_read_holds: assert property (@(posedge clk) disable iff (!reset_n)
    !do_read |=> $stable(cmd_rdata))
    else $error("read data moved without a read");
  a_other_quiet: assert property (@(posedge clk) disable iff (!reset_n)
    other_code |=> (!cmd_rvalid && $stable(port_power_mask) && $stable(fixed_device_flags)))
    else $error("foreign code acted on");
  a_write_silent: assert property (@(posedge clk) disable iff (!reset_n)
    do_write |=> !cmd_rvalid)
    else $error("write gave a read answer");

  // Field positions are written out as numbers here, so a wrong package offset shows up.
  // A write of all ones must still leave bit 0 of both fields clear.
  a_read_fields: assert property (@(posedge clk) disable iff (!reset_n)
    do_read |=> (cmd_rdata[18:16] == $past(port_power_mask)
                 && cmd_rdata[2:0] == $past(fixed_device_flags)))
    else $error("read fields misplaced");
  a_fixed_write: assert property (@(posedge clk) disable iff (!reset_n)
    do_write |=> (fixed_device_flags == ($past(cmd_wdata[2:0]) & 3'h6)))
    else $error("fixed field not stored");
  a_fields_hold: assert property (@(posedge clk) disable iff (!reset_n)
    !do_write |=> ($stable(port_power_mask) && $stable(fixed_device_flags)))
    else $error("field moved without a write");
  a_mask_bit0: assert property (@(posedge clk) disable iff (!reset_n)
    !port_power_mask[0])
    else $error("mask bit 0 set");

  // Global mode: both ports follow the global commands whatever the mask holds.
  a_global_off: assert property (@(posedge clk) disable iff (!reset_n)
    (!switch_select_bit && power_cmd.all_off) |=> port_powered_flag[2:1] == 2'h0)
    else $error("global mode off missed");
  a_global_hold: assert property (@(posedge clk) disable iff (!reset_n)
    (!switch_select_bit && !power_cmd.all_on && !power_cmd.all_off)
    |=> $stable(port_powered_flag))
    else $error("port moved without a global command");

  // Per-port mode, masked port: only its own commands move it, and off beats on.
  // Off wins so that a port being cut never stays powered through a racing on request.
  a_masked_on: assert property (@(posedge clk) disable iff (!reset_n)
    (switch_select_bit && port_power_mask[2] && power_cmd.port_on[2] && !power_cmd.port_off[2])
    |=> port_powered_flag[2])
    else $error("masked port 2 missed its on");
  a_port1_masked_on: assert property (@(posedge clk) disable iff (!reset_n)
    (switch_select_bit && port_power_mask[1] && power_cmd.port_on[1] && !power_cmd.port_off[1])
    |=> port_powered_flag[1])
    else $error("masked port 1 missed its on");
  a_masked_off: assert property (@(posedge clk) disable iff (!reset_n)
    (switch_select_bit && port_power_mask[1] && power_cmd.port_off[1])
    |=> !port_powered_flag[1])
    else $error("masked port 1 missed its off");
  a_port2_masked_off: assert property (@(posedge clk) disable iff (!reset_n)
    (switch_select_bit && port_power_mask[2] && power_cmd.port_off[2])
    |=> !port_powered_flag[2])
    else $error("masked port 2 missed its off");
  a_port2_masked_hold: assert property (@(posedge clk) disable iff (!reset_n)
    (switch_select_bit && port_power_mask[2] && !power_cmd.port_on[2] && !power_cmd.port_off[2])
    |=> $stable(port_powered_flag[2]))
    else $error("masked port 2 moved on global");

  // Per-port mode, unmasked port: per-port commands alone leave it, global ones move it.
  // This keeps a shared supply under one switch while other ports run on their own.
  a_unmasked_hold: assert property (@(posedge clk) disable iff (!reset_n)
    (switch_select_bit && !port_power_mask[2] && !power_cmd.all_on && !power_cmd.all_off)
    |=> $stable(port_powered_flag[2]))
    else $error("unmasked port 2 moved on per-port command");
  a_port1_unmasked_hold: assert property (@(posedge clk) disable iff (!reset_n)
    (switch_select_bit && !port_power_mask[1] && !power_cmd.all_on && !power_cmd.all_off)
    |=> $stable(port_powered_flag[1]))
    else $error("unmasked port 1 moved on per-port command");
  a_port2_unmasked_on: assert property (@(posedge clk) disable iff (!reset_n)
    (switch_select_bit && !port_power_mask[2] && power_cmd.all_on && !power_cmd.all_off)
    |=> port_powered_flag[2])
    else $error("unmasked port 2 missed global on");
  a_port1_unmasked_off: assert property (@(posedge clk) disable iff (!reset_n)
    (switch_select_bit && !port_power_mask[1] && power_cmd.all_off)
    |=> !port_powered_flag[1])
    else $error("unmasked port 1 missed global off");

endmodule : rhp_port_config

// ==== include/rhp_pkg.sv ====
package rhp_pkg;
  // Command codes seen on the controller's command port.
  localparam logic [7:0] RHP_CMD_READ  = 8'h13;
  localparam logic [7:0] RHP_CMD_WRITE = 8'h93;
  localparam int unsigned RHP_NUM_PORTS = 2;
  // Field positions inside the 32-bit register.
  localparam int unsigned RHP_MASK_LSB  = 16;
  localparam int unsigned RHP_FIXED_LSB = 0;
  localparam int unsigned RHP_FIELD_W   = 3;
  // Values after reset; implementation specific, software reprograms them.
  localparam logic [2:0] RHP_MASK_RESET  = 3'h0;
  localparam logic [2:0] RHP_FIXED_RESET = 3'h0;
  localparam logic [2:0] RHP_POWER_RESET = 3'h0;
  localparam logic [31:0] RHP_RDATA_RESET = 32'h0000_0000;
  localparam logic [2:0] RHP_PORT_BITS   = 3'h6;

  // Power command strobes for the ports; bit n of a vector is port n, bit 0 unused.
  typedef struct packed {
    logic       all_on;
    logic       all_off;
    logic [2:0] port_on;
    logic [2:0] port_off;
  } rhp_power_cmd_t;

  typedef enum logic {RHP_IDLE, RHP_BUSY} rhp_state_t;
endpackage : rhp_pkg

// ==== tb/tb_top.sv ====
`timescale 1ns/100ps
module tb_top;
  import rhp_pkg::*;
  logic           clk = 1'b0;
  logic           reset_n = 1'b0;
  logic           cmd_valid = 1'b0;
  logic [7:0]     cmd_code = 8'h00;
  logic [31:0]    cmd_wdata = 32'h0, cmd_rdata, m_rd;
  logic           switch_select_bit = 1'b0, cmd_rvalid, m_rv;
  rhp_power_cmd_t power_cmd = '0;
  logic [2:0]     port_powered_flag, fixed_device_flags, m_mask, m_fixed, m_pwr;
  int             miscompares = 0, n_tests = 0, cycles = 0, pick;
  rhp_port_config i_dut (.clk, .reset_n, .cmd_valid, .cmd_code, .cmd_wdata, .switch_select_bit,
    .power_cmd, .cmd_rdata, .cmd_rvalid, .port_powered_flag, .fixed_device_flags);
  // Free-running 100 MHz clock.
  initial begin
    forever #5 clk = ~clk;
  end
  // Masked ports take only their own command in per-port mode; off wins over on.
  function automatic logic next_pwr(input logic cur, sel, msk, on_g, off_g, on_p, off_p);
    logic on = (sel && msk) ? on_p : on_g;
    logic off = (sel && msk) ? off_p : off_g;
    return off ? 1'b0 : (on ? 1'b1 : cur);
  endfunction : next_pwr
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic end_of_test();
    $display("comparisons %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_of_test
  // A hang is cut short well beyond the expected run of about 420 cycles.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      miscompares++;
      end_of_test();
    end
  end
  // Random commands with two write-all-ones then read-back pairs at the start.
  initial begin
    void'($urandom(2));
    repeat (20) @(posedge clk);
    @(negedge clk) reset_n = 1'b1;
    {m_mask, m_fixed, m_pwr} = '0;
    m_rd = RHP_RDATA_RESET;
    chk(32'(fixed_device_flags), 32'(RHP_FIXED_RESET));
    for (int i = 0; i < 400; i++) begin
      @(negedge clk);
      pick = $urandom % 3;
      cmd_valid = (i < 4) || $urandom % 2;
      cmd_code = (i < 4) ? (i[0] ? RHP_CMD_READ : RHP_CMD_WRITE)
        : (pick == 0 ? RHP_CMD_READ : (pick == 1 ? RHP_CMD_WRITE : 8'($urandom)));
      cmd_wdata = (i < 4) ? 32'hFFFFFFFF : $urandom;
      switch_select_bit = 1'($urandom);
      power_cmd = rhp_power_cmd_t'(8'($urandom));
      @(posedge clk);
      for (int n = 1; n < 3; n++) m_pwr[n] = next_pwr(m_pwr[n], switch_select_bit, m_mask[n],
        power_cmd.all_on, power_cmd.all_off, power_cmd.port_on[n], power_cmd.port_off[n]);
      m_rv = cmd_valid && cmd_code == RHP_CMD_READ;
      if (m_rv) m_rd = {13'h0, m_mask, 13'h0, m_fixed};
      if (cmd_valid && cmd_code == RHP_CMD_WRITE) begin
        m_mask = cmd_wdata[18:16] & RHP_PORT_BITS;
        m_fixed = cmd_wdata[2:0] & RHP_PORT_BITS;
      end
      #1;
      chk(32'(cmd_rvalid), 32'(m_rv));
      chk(cmd_rdata, m_rd);
      chk(32'(port_powered_flag), 32'(m_pwr));
      chk(32'(fixed_device_flags), 32'(m_fixed));
    end
    $display("random command test done");
    // A reset in mid-run must bring every output and field back to its reset value.
    @(negedge clk);
    cmd_valid = 1'b0;
    power_cmd = '0;
    reset_n = 1'b0;
    @(negedge clk);
    reset_n = 1'b1;
    chk(cmd_rdata, RHP_RDATA_RESET);
    chk(32'(cmd_rvalid), 32'h0);
    chk(32'(port_powered_flag), 32'(RHP_POWER_RESET));
    chk(32'(fixed_device_flags), 32'(RHP_FIXED_RESET));
    cmd_valid = 1'b1;
    cmd_code = RHP_CMD_READ;
    @(posedge clk);
    #1;
    chk(32'(cmd_rvalid), 32'h1);
    chk(cmd_rdata, {13'h0, RHP_MASK_RESET & RHP_PORT_BITS, 13'h0, RHP_FIXED_RESET & RHP_PORT_BITS});
    @(negedge clk);
    cmd_valid = 1'b0;
    $display("mid-run reset test done");
    end_of_test();
  end
endmodule : tb_top
